/* rtl/mos_sequencer.sv */
// Muting override and error reset sequencer with its register port.
// Assumes error_in and field_clear come from logic on clk_sys; the
// button and muting sensors are pins and are synchronised here.
//
// Overview of operation
// (R1) One sensor active at interruption needs override
// (R2) Arm only on 0.15 to 4 s press
// (R3) Second held press turns outputs on
// (R4) Valid muting keeps outputs on, indicator lit
// (R5) Invalid muting: outputs only while button held
// (R6) Pause on release or beyond 150 s
// (R7) New held press continues a paused override
// (R8) Any error latches interlock, outputs off
// (R9) Without reset button, only power cycle clears
// (R10) With reset button, acknowledge clears interlock
// (R11) No override while an error is pending
// (R12) End muting on 0.3 s, 4 s, 10 min
// (R13) Override timer restarts at each continuation
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module mos_sequencer
    import mos_pkg::*;
#(
    parameter logic [CNT_W-1:0] PRESS_MIN_CYC = C_PRESS_MIN,
    parameter logic [CNT_W-1:0] PRESS_MAX_CYC = C_PRESS_MAX,
    parameter logic [CNT_W-1:0] OVR_MAX_CYC   = C_OVR_MAX,
    parameter logic [CNT_W-1:0] MUTE_BOTH_CYC = C_MUTE_BOTH,
    parameter logic [CNT_W-1:0] MUTE_ONE_CYC  = C_MUTE_ONE,
    parameter logic [CNT_W-1:0] MUTE_TMO_CYC  = C_MUTE_TMO
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              reset_button,
    input  wire logic              mute_sensor_a,
    input  wire logic              mute_sensor_b,
    input  wire logic              field_clear,
    input  wire logic              error_in,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic      [1:0]        safety_output_pair,
    output logic                   muting_indicator,
    output logic                   interlock,
    output logic                   irq
);
    // ------------------------------------------------------------
    // Pin synchronisers and button timer
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic       btn_s;
    logic       ma;
    logic       mb;
    logic       b_rise;
    logic       b_held;
    logic       b_rel_ok;

    mos_sync #(
        .W(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset  (reset),
        .d      ({reset_button, mute_sensor_a, mute_sensor_b}),
        .q      (pins_s)
    );

    assign btn_s = pins_s[2];
    assign ma    = pins_s[1];
    assign mb    = pins_s[0];

    mos_press #(
        .MIN_CYC(PRESS_MIN_CYC),
        .MAX_CYC(PRESS_MAX_CYC)
    ) u_press (
        .clk_sys(clk_sys),
        .reset  (reset),
        .btn    (btn_s),
        .rise   (b_rise),
        .held   (b_held),
        .rel_ok (b_rel_ok)
    );

    // ------------------------------------------------------------
    // Decoded control
    // ------------------------------------------------------------
    mos_core_s        r;
    mos_core_s        n;
    logic [2:0]       mode;
    logic             mute_en;
    logic             ack_en;
    logic             one_act;
    logic             both_act;
    logic             mute_end;
    logic [IRQ_W-1:0] ev;

    assign mode     = r.ctrl[CTRL_MODE_W-1:0];
    assign mute_en  = mos_mute_mode(mode);
    assign ack_en   = mos_ack_ok(mode, r.ctrl[CTRL_RES_BIT],
                                 r.ctrl[CTRL_BTN_BIT]); // R9 R10
    assign one_act  = ma ^ mb;
    assign both_act = ma & mb;
    assign mute_end = r.mute && ((r.both_cnt > MUTE_BOTH_CYC)
                    || (r.a_cnt > MUTE_ONE_CYC)
                    || (r.b_cnt > MUTE_ONE_CYC)
                    || (r.mute_cnt > MUTE_TMO_CYC)); // R12

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n       = r;
        n.rdata = '0;
        ev      = '0;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL:     n.ctrl = reg_wdata[CTRL_W-1:0];
                OFS_IRQ_MASK: n.imsk = reg_wdata[IRQ_W-1:0];
                OFS_IRQ_STAT: n.ist  = r.ist & ~reg_wdata[IRQ_W-1:0];
                default:      n.ctrl = n.ctrl;
            endcase
        end

        // Register reads, unmapped offsets answer zero
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:     n.rdata[CTRL_W-1:0] = r.ctrl;
                OFS_STATUS: begin
                    n.rdata[5:0]                    = r.st;
                    n.rdata[STS_MUTE_BIT]           = r.mute;
                    n.rdata[STS_NEED_BIT]           = r.need_ovr;
                    n.rdata[STS_PAIR_LSB+1:STS_PAIR_LSB] = r.pair;
                end
                OFS_IRQ_STAT: n.rdata[IRQ_W-1:0] = r.ist;
                OFS_IRQ_MASK: n.rdata[IRQ_W-1:0] = r.imsk;
                default:      n.rdata = '0;
            endcase
        end

        // Muting supervision; gaps below the limits are bridged
        if (r.mute) begin
            n.mute_cnt = r.mute_cnt + CNT_W'(1);
            n.a_cnt    = ma ? '0 : r.a_cnt + CNT_W'(1);
            n.b_cnt    = mb ? '0 : r.b_cnt + CNT_W'(1);
            n.both_cnt = (ma || mb) ? '0 : r.both_cnt + CNT_W'(1);
        end else begin
            n.mute_cnt = '0;
            n.a_cnt    = '0;
            n.b_cnt    = '0;
            n.both_cnt = '0;
        end
        if (mute_end) begin
            n.mute         = 1'b0; // R12
            ev[IRQ_MEND]   = 1'b1;
        end

        // Sequencer
        case (r.st)
            ST_RUN: begin
                if (!field_clear && !r.mute) begin
                    n.st       = ST_OFF;
                    n.need_ovr = one_act; // R1
                end else if (mute_en && both_act && !r.mute) begin
                    n.mute = 1'b1;
                end
            end
            ST_OFF: begin
                if (b_rel_ok && r.need_ovr) begin
                    n.st = ST_ARMED; // R2
                end else if (b_rel_ok) begin
                    n.st   = ST_RUN;
                    n.mute = mute_en && both_act;
                end
            end
            ST_ARMED: begin
                if (b_rise) begin
                    n.st        = ST_OVR; // R3
                    n.ovr_cnt   = '0;
                    ev[IRQ_OVR] = 1'b1;
                end
            end
            ST_OVR: begin
                n.ovr_cnt = r.ovr_cnt + CNT_W'(1);
                if (mute_en && both_act) begin
                    n.mute = 1'b1; // R4
                end
                if (r.ovr_cnt >= OVR_MAX_CYC) begin
                    n.st          = ST_PAUSE; // R6
                    n.mute        = 1'b0;
                    ev[IRQ_PAUSE] = 1'b1;
                end else if (!b_held && mute_en && both_act) begin
                    n.st       = ST_RUN; // R4
                    n.need_ovr = 1'b0;
                end else if (!b_held) begin
                    n.st          = ST_PAUSE; // R5
                    n.mute        = 1'b0;
                    ev[IRQ_PAUSE] = 1'b1;
                end
            end
            ST_PAUSE: begin
                // Only a fresh press continues; a button still held
                // past the time limit does not.
                if (b_rise) begin
                    n.st        = ST_OVR; // R7
                    n.ovr_cnt   = '0; // R13
                    ev[IRQ_OVR] = 1'b1;
                end
            end
            ST_ERR: begin
                // Presses here never start an override
                if (b_rel_ok && ack_en) begin
                    n.st       = ST_OFF; // R10 R11
                    n.need_ovr = 1'b0;
                end
            end
            default: begin
                n.st = ST_ERR;
            end
        endcase

        // Errors override the sequencer state and muting; other events of the same cycle are still recorded
        if (error_in) begin
            n.st         = ST_ERR; // R8
            n.mute       = 1'b0;
            ev[IRQ_ERR]  = r.st != ST_ERR;
        end

        n.pair = ((n.st == ST_RUN) || (n.st == ST_OVR)) ? PAIR_ON
                                                        : PAIR_OFF;
        // A new event wins over a clear in the same cycle
        n.ist = n.ist | ev;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // Power-up always starts with outputs off; no error latched
            r          <= '0;
            r.st       <= ST_OFF;
            r.ctrl     <= CTRL_RST;
            r.ist      <= IRQ_RST;
            r.imsk     <= IRQ_RST;
            r.pair     <= PAIR_OFF;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata          = r.rdata;
    assign safety_output_pair = r.pair;
    assign muting_indicator   = r.mute;
    assign interlock          = r.st == ST_ERR;
    assign irq                = |(r.ist & r.imsk);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_armed_press;
        (r.st == ST_ARMED) && b_rise && !error_in;
    endsequence

    sequence s_pair_on;
        (r.st == ST_OVR) && (safety_output_pair == PAIR_ON);
    endsequence

    sequence s_pause_press;
        (r.st == ST_PAUSE) && b_rise && !error_in;
    endsequence

    chk_one_sensor_stop: assert property ( // R1
        (r.st == ST_RUN) && !field_clear && !r.mute && one_act
        && !error_in |=> (r.st == ST_OFF) && r.need_ovr
            && (safety_output_pair == PAIR_OFF))
        else $error("single sensor stop did not require override");

    chk_arm_window: assert property ( // R2
        (r.st == ST_OFF) && r.need_ovr && !error_in
        |=> (r.st == ST_ARMED) == $past(b_rel_ok))
        else $error("override armed without a valid press");

    chk_override_start: assert property ( // R3
        s_armed_press |=> s_pair_on)
        else $error("second press did not start override");

    chk_valid_muting: assert property ( // R4
        (r.st == ST_OVR) && !b_held && mute_en && both_act
        && (r.ovr_cnt < OVR_MAX_CYC) && !error_in
        |=> (r.st == ST_RUN) && muting_indicator
            && (safety_output_pair == PAIR_ON))
        else $error("valid muting did not keep outputs on");

    chk_release_pause: assert property ( // R5
        (r.st == ST_OVR) && !b_held && !(mute_en && both_act)
        && !error_in |=> (r.st == ST_PAUSE)
            && (safety_output_pair == PAIR_OFF))
        else $error("release without muting left outputs on");

    chk_override_limit: assert property ( // R6
        (r.st == ST_OVR) |-> (r.ovr_cnt <= OVR_MAX_CYC))
        else $error("override ran past its time limit");

    chk_continue_jog: assert property ( // R7 R13
        s_pause_press |=> s_pair_on ##0 (r.ovr_cnt == '0)
            ##1 (r.ovr_cnt == CNT_W'(1)) || (r.st != ST_OVR))
        else $error("paused override did not continue from zero");

    chk_error_latch: assert property ( // R8
        error_in |=> (r.st == ST_ERR) && interlock
            && (safety_output_pair == PAIR_OFF))
        else $error("error did not latch interlock");

    chk_power_cycle_only: assert property ( // R9
        (r.st == ST_ERR) && !ack_en |=> (r.st == ST_ERR))
        else $error("interlock left without a power cycle");

    chk_error_ack: assert property ( // R10
        (r.st == ST_ERR) && b_rel_ok && ack_en && !error_in
        |=> (r.st == ST_OFF) ##1 (r.st != ST_OVR))
        else $error("acknowledge did not clear interlock");

    chk_no_override_err: assert property ( // R11
        (r.st == ST_ERR) |=> (r.st != ST_OVR) && (r.st != ST_ARMED))
        else $error("override accepted while error pending");

    chk_mute_end: assert property ( // R12
        r.mute && (r.mute_cnt > MUTE_TMO_CYC) |=> !muting_indicator)
        else $error("muting outlived its timeout");

    chk_irq_sticky: assert property (
        $rose(r.st == ST_ERR) |-> r.ist[IRQ_ERR])
        else $error("error event not recorded");
endmodule

/* rtl/mos_pkg.sv */
// Constants and types of the muting override sequencer.
// Assumes one 125 MHz system clock and a synchronous reset.
package mos_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int     CNT_W          = 37;
    localparam longint CLK_HZ         = 125000000;
    localparam longint MS_PER_S       = 1000;
    localparam longint T_PRESS_MIN_MS = 150;
    localparam longint T_PRESS_MAX_MS = 4000;
    localparam longint T_OVR_MAX_MS   = 150000;
    localparam longint T_MUTE_BOTH_MS = 300;
    localparam longint T_MUTE_ONE_MS  = 4000;
    localparam longint T_MUTE_TMO_MS  = 600000;
    // Least times round up, longest times round down
    localparam logic [CNT_W-1:0] C_PRESS_MIN = CNT_W'(
        (T_PRESS_MIN_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S);
    localparam logic [CNT_W-1:0] C_PRESS_MAX = CNT_W'(
        T_PRESS_MAX_MS * CLK_HZ / MS_PER_S);
    localparam logic [CNT_W-1:0] C_OVR_MAX = CNT_W'(
        T_OVR_MAX_MS * CLK_HZ / MS_PER_S);
    localparam logic [CNT_W-1:0] C_MUTE_BOTH = CNT_W'(
        T_MUTE_BOTH_MS * CLK_HZ / MS_PER_S);
    localparam logic [CNT_W-1:0] C_MUTE_ONE = CNT_W'(
        T_MUTE_ONE_MS * CLK_HZ / MS_PER_S);
    localparam logic [CNT_W-1:0] C_MUTE_TMO = CNT_W'(
        T_MUTE_TMO_MS * CLK_HZ / MS_PER_S);

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 4;
    localparam int         DATA_W       = 32;
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_STATUS   = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
    localparam int         CTRL_W       = 5;
    localparam int         CTRL_MODE_W  = 3;
    localparam int         CTRL_RES_BIT = 3;
    localparam int         CTRL_BTN_BIT = 4;
    localparam logic [4:0] CTRL_RST     = 5'h1C;
    localparam int         IRQ_W        = 4;
    localparam int         IRQ_ERR      = 0;
    localparam int         IRQ_OVR      = 1;
    localparam int         IRQ_PAUSE    = 2;
    localparam int         IRQ_MEND     = 3;
    localparam logic [3:0] IRQ_RST      = 4'h0;
    localparam int         STS_MUTE_BIT = 6;
    localparam int         STS_NEED_BIT = 7;
    localparam int         STS_PAIR_LSB = 8;
    localparam logic [1:0] PAIR_ON      = 2'h3;
    localparam logic [1:0] PAIR_OFF     = 2'h0;
    localparam logic [2:0] MODE_1       = 3'h1;
    localparam logic [2:0] MODE_3       = 3'h3;
    localparam logic [2:0] MODE_4       = 3'h4;
    localparam logic [2:0] MODE_6       = 3'h6;

    // ------------------------------------------------------------
    // Types and decoders
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_RUN   = 6'h01,
        ST_OFF   = 6'h02,
        ST_ARMED = 6'h04,
        ST_OVR   = 6'h08,
        ST_PAUSE = 6'h10,
        ST_ERR   = 6'h20
    } mos_state_e;

    typedef struct packed {
        mos_state_e         st;
        logic               need_ovr;
        logic               mute;
        logic [1:0]         pair;
        logic [CNT_W-1:0]   ovr_cnt;
        logic [CNT_W-1:0]   both_cnt;
        logic [CNT_W-1:0]   a_cnt;
        logic [CNT_W-1:0]   b_cnt;
        logic [CNT_W-1:0]   mute_cnt;
        logic [CTRL_W-1:0]  ctrl;
        logic [IRQ_W-1:0]   ist;
        logic [IRQ_W-1:0]   imsk;
        logic [DATA_W-1:0]  rdata;
    } mos_core_s;

    function automatic logic mos_mute_mode(input logic [2:0] mode);
        return (mode == MODE_4) || (mode == MODE_6);
    endfunction

    function automatic logic mos_ack_ok(input logic [2:0] mode,
                                        input logic       res,
                                        input logic       btn);
        return ((mode >= MODE_1) && (mode <= MODE_3) && !res && btn)
            || (mos_mute_mode(mode) && res);
    endfunction
endpackage

/* rtl/mos_sync.sv */
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module mos_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mos_sync_s;

    mos_sync_s st_r;
    mos_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        // First stage feeds only the second
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

/* rtl/mos_press.sv */
// Reset button press timer: press edge, held level, timed release.
// Assumes the button input is already synchronised to clk_sys.
`timescale 1ns/1ps
module mos_press
    import mos_pkg::*;
#(
    parameter logic [CNT_W-1:0] MIN_CYC = C_PRESS_MIN,
    parameter logic [CNT_W-1:0] MAX_CYC = C_PRESS_MAX
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic btn,
    output logic      rise,
    output logic      held,
    output logic      rel_ok
);
    typedef struct packed {
        logic             prev;
        logic [CNT_W-1:0] cnt;
        logic             rise;
        logic             rel_ok;
    } mos_press_s;

    mos_press_s st_r;
    mos_press_s st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.prev   = btn;
        st_nxt.rise   = btn && !st_r.prev;
        st_nxt.rel_ok = !btn && st_r.prev
                     && (st_r.cnt >= MIN_CYC) && (st_r.cnt <= MAX_CYC); // R2
        // Saturate so a stuck button never wraps into the window
        if (!btn) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt != '1) begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise   = st_r.rise;
    assign held   = st_r.prev;
    assign rel_ok = st_r.rel_ok;
endmodule

/* testbench/mos_partner.sv */
// Pin model of the reset button and the two muting sensors.
// Assumes the bench sets the wanted levels; pins move on clk_sys.
`timescale 1ns/1ps
module mos_partner (
    input  wire logic clk_sys,
    input  wire logic press,
    input  wire logic sens_a,
    input  wire logic sens_b,
    output logic      reset_button,
    output logic      mute_sensor_a,
    output logic      mute_sensor_b
);
    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // Contacts are bounce free; the press window is the design's job
    always @(posedge clk_sys) begin
        reset_button  <= press;
        mute_sensor_a <= sens_a;
        mute_sensor_b <= sens_b;
    end
endmodule

/* testbench/muting_override_sequencer_tb.sv */
// Self-checking bench of the muting override sequencer.
// Assumes the pin model drives the button and both sensors.
`timescale 1ns/1ps
module muting_override_sequencer_tb;
    import mos_pkg::*;
    // ------------------------------------------------------------
    // Set-up
    // ------------------------------------------------------------
    localparam int PMIN = 5;
    localparam int PMAX = 20;
    logic              clk_sys, reset, press, sa, sb, btn, ma, mb;
    logic              field_clear, error_in, reg_wr, reg_rd, irq;
    logic              muting_indicator, interlock;
    logic [3:0]        reg_addr;
    logic [31:0]       reg_wdata, reg_rdata;
    logic [1:0]        safety_output_pair;
    int                n_mismatch, checks_done;

    mos_partner mos_partner_inst (.clk_sys(clk_sys), .press(press),
        .sens_a(sa), .sens_b(sb), .reset_button(btn),
        .mute_sensor_a(ma), .mute_sensor_b(mb));
    // Short counts keep the run small; expectations use the same
    mos_sequencer #(.PRESS_MIN_CYC(CNT_W'(PMIN)),
        .PRESS_MAX_CYC(CNT_W'(PMAX)), .OVR_MAX_CYC(CNT_W'(30)),
        .MUTE_BOTH_CYC(CNT_W'(6)), .MUTE_ONE_CYC(CNT_W'(12)),
        .MUTE_TMO_CYC(CNT_W'(50))) mos_sequencer_inst (
        .clk_sys(clk_sys), .reset(reset), .reset_button(btn),
        .mute_sensor_a(ma), .mute_sensor_b(mb),
        .field_clear(field_clear), .error_in(error_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .safety_output_pair(safety_output_pair),
        .muting_indicator(muting_indicator), .interlock(interlock),
        .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic cr(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // Polling is bounded; a state never reached ends the run
    task automatic wait_st(input logic [5:0] e);
        logic [31:0] d;
        for (int i = 0; i < 80; i++) begin
            rd(OFS_STATUS, d);
            if (d[5:0] === e) break;
        end
        chk(d[5:0], e);
        if (d[5:0] !== e) end_sim();
    endtask
    task automatic st_now(input logic [5:0] e);
        logic [31:0] d;
        repeat (12) @(posedge clk_sys);
        rd(OFS_STATUS, d);
        chk(d[5:0], e);
    endtask
    task automatic hold(input logic v);
        @(posedge clk_sys);
        press <= v;
    endtask
    task automatic push(input int n);
        hold(1'b1);
        repeat (n) @(posedge clk_sys);
        press <= 1'b0;
    endtask
    function automatic int rlen();
        return PMIN + int'($urandom % (PMAX - PMIN + 1));
    endfunction
    function automatic logic [5:0] ack_st(input logic [4:0] c);
        if ((c[2:0] >= 3'h1 && c[2:0] <= 3'h3 && !c[3] && c[4]) ||
            ((c[2:0] == 3'h4 || c[2:0] == 3'h6) && c[3]))
            return ST_OFF;
        return ST_ERR;
    endfunction

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [4:0] ct [6] = '{5'h11, 5'h12, 5'h13, 5'h1E, 5'h14, 5'h01};
        int         n;
        {reset, press, sa, sb, error_in, reg_wr, reg_rd} = 7'h40;
        field_clear = 1'b1;
        reg_addr    = 4'h0;
        reg_wdata   = 32'h0;
        void'($urandom(50677));
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        cr(OFS_CTRL, 32'h1C);
        cr(OFS_STATUS, 32'h2);
        cr(OFS_IRQ_STAT, 32'h0);
        wr(4'h2, 32'hFFFFFFFF);
        cr(4'h2, 32'h0);
        wr(OFS_IRQ_MASK, 32'hFFFFFFFF);
        cr(OFS_IRQ_MASK, 32'hF);
        push(rlen());
        wait_st(ST_RUN);
        chk(safety_output_pair, PAIR_ON);
        // Sensor first, so the field cut sees exactly one active
        @(posedge clk_sys);
        sa <= 1'b1;
        repeat (4) @(posedge clk_sys);
        field_clear <= 1'b0;
        wait_st(ST_OFF);
        cr(OFS_STATUS, 32'h82);
        @(posedge clk_sys);
        field_clear <= 1'b1;
        push(PMIN - 2);
        st_now(ST_OFF);
        push(PMAX + 4);
        st_now(ST_OFF);
        push(PMIN);
        wait_st(ST_ARMED);
        hold(1'b1);
        wait_st(ST_OVR);
        chk(safety_output_pair, PAIR_ON);
        repeat (15) @(posedge clk_sys);
        hold(1'b0);
        wait_st(ST_PAUSE);
        chk(safety_output_pair, PAIR_OFF);
        hold(1'b1);
        wait_st(ST_OVR);
        repeat (20) @(posedge clk_sys);
        hold(1'b0);
        wait_st(ST_PAUSE);
        hold(1'b1);
        wait_st(ST_OVR);
        st_now(ST_OVR);
        wait_st(ST_PAUSE);
        chk(safety_output_pair, PAIR_OFF);
        hold(1'b0);
        repeat (8) @(posedge clk_sys);
        hold(1'b1);
        sb <= 1'b1;
        wait_st(ST_OVR);
        repeat (6) @(posedge clk_sys);
        hold(1'b0);
        wait_st(ST_RUN);
        chk(safety_output_pair, PAIR_ON);
        chk(muting_indicator, 1'b1);
        // Outlast the muting timeout once; both active restarts it
        repeat (60) @(posedge clk_sys);
        @(posedge clk_sys);
        sa <= 1'b0;
        sb <= 1'b0;
        for (n = 1; n < 30; n++) begin
            @(posedge clk_sys);
            #1;
            if (muting_indicator !== 1'b1) break;
        end
        chk(n >= 6 && n <= 20, 1'b1);
        // One sensor gone: muting ends after the longer limit
        @(posedge clk_sys);
        sa <= 1'b1;
        sb <= 1'b1;
        repeat (6) @(posedge clk_sys);
        sa <= 1'b0;
        #1 chk(muting_indicator, 1'b1);
        repeat (14) @(posedge clk_sys);
        #1 chk(muting_indicator, 1'b1);
        repeat (5) @(posedge clk_sys);
        #1 chk(muting_indicator, 1'b0);
        chk(irq, 1'b1);
        cr(OFS_IRQ_STAT, 32'hE);
        wr(OFS_IRQ_STAT, 32'hF);
        cr(OFS_IRQ_STAT, 32'h0);
        chk(irq, 1'b0);
        // Masked event: sticky bit set, output line stays low
        wr(OFS_IRQ_MASK, 32'h0);
        @(posedge clk_sys);
        error_in <= 1'b1;
        @(posedge clk_sys);
        error_in <= 1'b0;
        wait_st(ST_ERR);
        chk(interlock, 1'b1);
        chk(safety_output_pair, PAIR_OFF);
        chk(irq, 1'b0);
        cr(OFS_IRQ_STAT, 32'h1);
        hold(1'b1);
        st_now(ST_ERR);
        hold(1'b0);
        wait_st(ST_OFF);
        chk(interlock, 1'b0);
        foreach (ct[i]) begin
            wr(OFS_CTRL, {27'h0, ct[i]});
            cr(OFS_CTRL, {27'h0, ct[i]});
            @(posedge clk_sys);
            error_in <= 1'b1;
            @(posedge clk_sys);
            error_in <= 1'b0;
            wait_st(ST_ERR);
            push(rlen());
            st_now(ack_st(ct[i]));
        end
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        wait_st(ST_OFF);
        chk(interlock, 1'b0);
        end_sim();
    end
endmodule
